// ==== design/sensor_serial_pkg.sv ====
// Summary of operation
// R1: device answers address byte 32 for writes and 33 for reads.
// R2: master sends read/write bit zero in every write message.
// R3: index msb picks auto-increment; when clear, index stays after data write.
// R4: stored index survives the end of a write message.
// R5: master ends every write message with a stop.
// R6: read message has no index; first byte comes from stored index.
// R7: master ends each read with a not-acknowledge after its last byte.
// R8: index-only write sets the index and changes no register.
// R9: index write may be joined to the read by repeated start.
// R10: without increment, successive written bytes land in the same register.
// R11: setup bit 1 written low, high, low starts black calibration.
// R12: fine, coarse and divider values apply from the next frame.
// R13: gain applies one frame after the other exposure values.
// R14: exposure or gain write sets pending flag; next frame start clears it.
// R15: without increment, every acknowledged read byte repeats the same register.
// R16: with increment, written bytes go to consecutive locations.
// R17: with increment, one read returns several consecutive locations.
// R18: after final not-acknowledge device releases bus, needs no stop.
// R19: exposure retiming is suspended while the exposure page is written.
// R20: supplied input clock runs 16 cycles around start and stop.
// R21: with increment, index advances after each transmitted read byte.
package sensor_serial_pkg;
    localparam int INDEX_W = 7;
    localparam logic [7:0] DEV_WRITE_ADDR = 8'h20;
    localparam logic [7:0] DEV_READ_ADDR = 8'h21;
    localparam logic [6:0] IDX_FINE_HI = 7'h20;
    localparam logic [6:0] IDX_FINE_LO = 7'h21;
    localparam logic [6:0] IDX_COARSE_HI = 7'h22;
    localparam logic [6:0] IDX_COARSE_LO = 7'h23;
    localparam logic [6:0] IDX_GAIN = 7'h24;
    localparam logic [6:0] IDX_CLK_DIV = 7'h25;
    localparam logic [6:0] IDX_EXPO_FIRST = 7'h20;
    localparam logic [6:0] IDX_EXPO_LAST = 7'h29;
    localparam logic [6:0] IDX_FIRST_STATUS = 7'h00;
    localparam logic [6:0] IDX_FIRST_SETUP = 7'h11;
    localparam int PENDING_BIT = 0;
    localparam int CAL_BIT = 1;
    localparam int GAIN_W = 3;
    localparam int CLK_DIV_W = 2;
    localparam logic [15:0] FINE_RESET = 16'h0000;
    localparam logic [15:0] COARSE_RESET = 16'h012e;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [1:0] CLK_DIV_RESET = 2'h0;

    typedef struct packed {
        logic [15:0] fine;
        logic [15:0] coarse;
        logic [1:0] clk_div;
    } expo_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } serial_in_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INDEX = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_ACK_TX = 3'b101,
        ST_ACK_RX = 3'b110
    } serial_state_t;
endpackage

// ==== design/sensor_serial_regs.sv ====
`timescale 1ns/10ps
module sensor_serial_regs #(
    parameter int REG_COUNT = 128
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    // serial pins, open drain data
    input wire sensor_serial_pkg::serial_in_t i_serial,
    output logic o_sda_out,
    output logic o_sda_oe,
    // video timing
    input wire logic i_frame_start,
    // applied settings and status
    output sensor_serial_pkg::expo_t o_exposure,
    output logic [2:0] o_gain,
    output logic o_pending,
    output logic o_black_cal_start
);
    import sensor_serial_pkg::*;

    if (REG_COUNT != 2 ** INDEX_W) begin : g_bad_count
        $error("REG_COUNT must equal the index range");
    end

    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic scl_q;
    logic sda_q;
    serial_state_t state_q;
    serial_state_t after_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [6:0] index_q;
    logic inc_q;
    logic acked_q;
    logic oe_q;
    logic out_q;
    logic [7:0] mem_q [REG_COUNT];
    logic pending_q;
    logic hold_q;
    logic [1:0] cal_seq_q;
    logic cal_q;
    expo_t expo_q;
    logic [2:0] gain_stage_q;
    logic [2:0] gain_q;

    function automatic logic in_expo(input logic [6:0] idx);
        in_expo = (idx >= IDX_EXPO_FIRST) && (idx <= IDX_EXPO_LAST);
    endfunction

    function automatic logic [7:0] read_byte(input logic [6:0] idx);
        if (idx == IDX_FIRST_STATUS) begin
            read_byte = 8'h00;
            read_byte[PENDING_BIT] = pending_q;
        end else begin
            read_byte = mem_q[idx];
        end
    endfunction

    // the synced levels; the first stage feeds only the second
    wire scl_s = scl_sync_q[1];
    wire sda_s = sda_sync_q[1];
    wire scl_rise = scl_s && !scl_q;
    wire scl_fall = !scl_s && scl_q;
    wire start_cond = scl_s && scl_q && sda_q && !sda_s;
    wire stop_cond = scl_s && scl_q && !sda_q && sda_s;
    wire rx_state = (state_q == ST_ADDR) || (state_q == ST_INDEX) ||
        (state_q == ST_WDATA);
    wire byte_done = rx_state && scl_fall && (bit_q == 4'h8);
    wire addr_hit = (shift_q == DEV_WRITE_ADDR) || (shift_q == DEV_READ_ADDR);
    wire wr_en = byte_done && (state_q == ST_WDATA);
    wire [6:0] index_next = inc_q ? index_q + 7'h01 : index_q;
    wire expo_wr = wr_en && in_expo(index_q);
    wire setup_wr = wr_en && (index_q == IDX_FIRST_SETUP);
    wire apply = i_frame_start && !hold_q && !expo_wr;
    // a bit-select on a call result is refused by strict front ends
    wire [7:0] cur_byte = read_byte(index_q);

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], i_serial.scl};
            sda_sync_q <= {sda_sync_q[0], i_serial.sda};
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // byte engine; start and stop override any bit in flight
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            state_q <= ST_IDLE;
            after_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            index_q <= 7'h00;
            inc_q <= 1'b0;
            acked_q <= 1'b0;
            oe_q <= 1'b0;
            out_q <= 1'b0;
        end else if (start_cond) begin
            state_q <= ST_ADDR; // R9
            bit_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= ST_IDLE; // R4
            oe_q <= 1'b0;
        end else if (rx_state && scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
        end else if (byte_done) begin
            bit_q <= 4'h0;
            oe_q <= 1'b1;
            state_q <= ST_ACK_TX;
            unique case (state_q)
                ST_ADDR: begin
                    oe_q <= addr_hit; // R1
                    state_q <= addr_hit ? ST_ACK_TX : ST_IDLE;
                    after_q <= shift_q[0] ? ST_RDATA : ST_INDEX;
                    tx_q <= read_byte(index_q); // R6
                end
                ST_INDEX: begin
                    index_q <= shift_q[6:0]; // R8
                    inc_q <= shift_q[7]; // R3
                    after_q <= ST_WDATA;
                end
                ST_WDATA: begin
                    index_q <= index_next; // R3 R10 R16
                    after_q <= ST_WDATA;
                end
            endcase
        end else if (state_q == ST_ACK_TX && scl_fall) begin
            state_q <= after_q;
            oe_q <= (after_q == ST_RDATA) && !tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            bit_q <= (after_q == ST_RDATA) ? 4'h1 : 4'h0;
        end else if (state_q == ST_RDATA && scl_fall) begin
            if (bit_q == 4'h8) begin
                oe_q <= 1'b0;
                state_q <= ST_ACK_RX;
            end else begin
                oe_q <= !tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
            end
        end else if (state_q == ST_ACK_RX && scl_rise) begin
            acked_q <= !sda_s;
            index_q <= index_next; // R21 R17
        end else if (state_q == ST_ACK_RX && scl_fall) begin
            // a nack ends the read here, whether or not a stop follows
            state_q <= acked_q ? ST_RDATA : ST_IDLE; // R18
            oe_q <= acked_q && !cur_byte[7];
            tx_q <= {cur_byte[6:0], 1'b0}; // R15
            bit_q <= 4'h1;
        end
    end

    // register image; the status location is read-only
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                mem_q[i] <= 8'h00;
            end
            mem_q[IDX_COARSE_HI] <= COARSE_RESET[15:8];
            mem_q[IDX_COARSE_LO] <= COARSE_RESET[7:0];
        end else if (wr_en && index_q != IDX_FIRST_STATUS) begin
            mem_q[index_q] <= shift_q; // R10 R16
        end
    end

    // hold lasts from the first exposure write to the end of the message so a burst is never split across frames
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            hold_q <= 1'b0;
            pending_q <= 1'b0;
        end else begin
            if (start_cond || stop_cond) begin
                hold_q <= 1'b0;
            end else if (expo_wr) begin
                hold_q <= 1'b1; // R19
            end
            if (expo_wr) begin
                pending_q <= 1'b1; // R14
            end else if (apply) begin
                pending_q <= 1'b0; // R14
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            expo_q <= '{FINE_RESET, COARSE_RESET, CLK_DIV_RESET};
            gain_stage_q <= GAIN_RESET;
            gain_q <= GAIN_RESET;
        end else if (apply) begin
            expo_q.fine <= {mem_q[IDX_FINE_HI], mem_q[IDX_FINE_LO]}; // R12
            expo_q.coarse <= {mem_q[IDX_COARSE_HI], mem_q[IDX_COARSE_LO]};
            expo_q.clk_div <= mem_q[IDX_CLK_DIV][CLK_DIV_W-1:0];
            gain_stage_q <= mem_q[IDX_GAIN][GAIN_W-1:0];
            gain_q <= gain_stage_q; // R13
        end
    end

    // calibration needs low, one or more highs, then low on successive setup writes
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            cal_seq_q <= 2'h0;
            cal_q <= 1'b0;
        end else begin
            cal_q <= 1'b0;
            if (setup_wr) begin
                if (shift_q[CAL_BIT]) begin
                    cal_seq_q <= (cal_seq_q != 2'h0) ? 2'h2 : 2'h0;
                end else begin
                    cal_seq_q <= 2'h1;
                    cal_q <= (cal_seq_q == 2'h2); // R11
                end
            end
        end
    end

    assign o_sda_oe = oe_q;
    assign o_sda_out = out_q;
    assign o_exposure = expo_q;
    assign o_gain = gain_q;
    assign o_pending = pending_q;
    assign o_black_cal_start = cal_q;

    sequence s_addr_taken;
        byte_done && state_q == ST_ADDR && addr_hit;
    endsequence

    a_addr_ack_drive: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R1
        s_addr_taken ##1 !start_cond && !stop_cond |-> o_sda_oe)
        else $error("address match not acknowledged");
    a_pending_set: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R14
        expo_wr |=> o_pending)
        else $error("pending flag not set by exposure write");
    a_pending_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R14
        i_frame_start && !hold_q && !expo_wr |=> !o_pending)
        else $error("pending flag not cleared at frame start");
    a_index_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R10
        wr_en && !inc_q && !start_cond && !stop_cond |=> $stable(index_q))
        else $error("index moved without increment");
    a_index_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R16
        wr_en && inc_q && !start_cond && !stop_cond
        |=> index_q == $past(index_q) + 7'h01)
        else $error("index did not step");
    a_gain_lag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R13
        apply |=> o_gain == $past(gain_stage_q))
        else $error("gain not one frame behind");
    a_expo_frozen: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R19
        hold_q && i_frame_start |=> $stable(o_exposure) && $stable(o_gain))
        else $error("exposure retimed during page write");
    a_expo_apply: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R12
        apply |=> o_exposure.fine == $past({mem_q[IDX_FINE_HI],
        mem_q[IDX_FINE_LO]}))
        else $error("fine exposure not applied");
    a_cal_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R11
        o_black_cal_start |-> $past(setup_wr) && !$past(shift_q[CAL_BIT])
        && $past(cal_seq_q) == 2'h2)
        else $error("calibration started without low high low");
    a_nack_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R18
        state_q == ST_ACK_RX && scl_fall && !acked_q && !start_cond && !stop_cond
        |=> state_q == ST_IDLE && !o_sda_oe [*2])
        else $error("bus not released after nack");
endmodule // sensor_serial_regs

// ==== verif/sensor_serial_register_access_tb.sv ====
`timescale 1ns/10ps
module sensor_serial_register_access_tb;
    import sensor_serial_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_frame_start = 1'b0;
    serial_in_t i_serial;
    logic o_sda_out, o_sda_oe, o_pending, o_black_cal_start;
    expo_t o_exposure;
    logic [2:0] o_gain;
    int err_count = 0;
    int checks = 0;
    int cycles = 0;
    int cal_count = 0;
    logic [7:0] rd;
    logic ack;
    logic [7:0] burst [6] = '{8'h55, 8'h00, 8'h00, 8'h10, 8'h05, 8'h02};

    serial_master_model mst_u (.i_core_clk(i_core_clk), .i_sda_out(o_sda_out),
        .i_sda_oe(o_sda_oe), .o_serial(i_serial));
    sensor_serial_regs dut_u (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_serial(i_serial), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
        .i_frame_start(i_frame_start), .o_exposure(o_exposure),
        .o_gain(o_gain), .o_pending(o_pending),
        .o_black_cal_start(o_black_cal_start));

    always #5 i_core_clk = ~i_core_clk;
    // ceiling well above the roughly 5900 cycles the sequence needs
    always @(posedge i_core_clk) begin
        cycles = cycles + 1;
        if (o_black_cal_start === 1'b1) cal_count = cal_count + 1;
        if (cycles == 30000) begin
            err_count = err_count + 1;
            test_done();
        end
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        mst_u.wr_byte(d, ack);
        chk(34'(ack), 34'h1);
    endtask
    task automatic rdb(input logic last, input logic [7:0] exp);
        mst_u.rd_byte(last, rd);
        chk(34'(rd), 34'(exp));
    endtask
    task automatic frame();
        @(posedge i_core_clk);
        i_frame_start <= 1'b1;
        @(posedge i_core_clk);
        i_frame_start <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        @(posedge i_core_clk);
        chk(o_exposure, {FINE_RESET, COARSE_RESET, CLK_DIV_RESET});
        chk(34'({o_gain, o_pending, o_sda_oe, o_sda_out}),
            34'({GAIN_RESET, 3'b000}));
        $display("test reset done");
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b0, IDX_FINE_HI});
        wr(8'h55);
        frame();
        chk(34'(o_pending), 34'h1);
        chk(34'(o_exposure.fine), 34'(FINE_RESET));
        mst_u.stop();
        frame();
        chk(o_exposure, {16'h5500, COARSE_RESET, CLK_DIV_RESET});
        chk(34'(o_pending), 34'h0);
        mst_u.start();
        wr(DEV_READ_ADDR);
        rdb(1'b1, 8'h55);
        repeat (4) @(posedge i_core_clk);
        chk(34'(o_sda_oe), 34'h0);
        mst_u.start();
        mst_u.wr_byte(8'h40, ack);
        chk(34'(ack), 34'h0);
        mst_u.stop();
        $display("test single write and read done");
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b1, IDX_COARSE_HI});
        for (int i = 2; i < 6; i++) begin
            wr(burst[i]);
        end
        mst_u.stop();
        frame();
        chk(o_exposure, {16'h5500, 16'h0010, 2'h2});
        chk(34'(o_gain), 34'(GAIN_RESET));
        frame();
        chk(34'(o_gain), 34'h5);
        $display("test burst write and gain lag done");
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b0, 7'h26});
        wr(8'h11);
        wr(8'h22);
        mst_u.stop();
        mst_u.start();
        wr(DEV_READ_ADDR);
        rdb(1'b1, 8'h22);
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b0, IDX_FIRST_SETUP});
        wr(8'h00);
        wr(8'h02);
        wr(8'h00);
        mst_u.stop();
        chk(34'(cal_count), 34'h1);
        $display("test same location write done");
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b0, IDX_GAIN});
        mst_u.start();
        wr(DEV_READ_ADDR);
        rdb(1'b0, 8'h05);
        rdb(1'b0, 8'h05);
        rdb(1'b1, 8'h05);
        $display("test repeated read done");
        mst_u.start();
        wr(DEV_WRITE_ADDR);
        wr({1'b1, IDX_FINE_HI});
        mst_u.start();
        wr(DEV_READ_ADDR);
        for (int i = 0; i < 6; i++) begin
            rdb(i == 5, burst[i]);
        end
        mst_u.start();
        wr(DEV_READ_ADDR);
        rdb(1'b1, 8'h22);
        mst_u.stop();
        $display("test burst read done");
        test_done();
    end
endmodule // sensor_serial_register_access_tb

// ==== verif/serial_master_model.sv ====
`timescale 1ns/10ps
module serial_master_model
    import sensor_serial_pkg::*;
#(
    parameter int HALF = 6
) (
    // clock
    input wire logic i_core_clk,
    // device data drive
    input wire logic i_sda_out,
    input wire logic i_sda_oe,
    // pins toward device
    output sensor_serial_pkg::serial_in_t o_serial
);
    import sensor_serial_pkg::*;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // pull-up on the data line only: a released data line reads high, never stale
    assign o_serial.scl = scl_q;
    assign o_serial.sda = sda_q & (i_sda_out | ~i_sda_oe);

    task automatic half();
        repeat (HALF) @(posedge i_core_clk);
    endtask
    // also a repeated start when entered with the clock low
    task automatic start();
        @(posedge i_core_clk);
        sda_q <= 1'b1;
        half();
        scl_q <= 1'b1;
        half();
        sda_q <= 1'b0;
        half();
        scl_q <= 1'b0;
        half();
    endtask
    task automatic stop();
        @(posedge i_core_clk);
        sda_q <= 1'b0;
        half();
        scl_q <= 1'b1;
        half();
        sda_q <= 1'b1;
        half();
    endtask
    // data moves three edges after the clock fall, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        @(posedge i_core_clk);
        sda_q <= b;
        half();
        scl_q <= 1'b1;
        half();
        r = o_serial.sda;
        scl_q <= 1'b0;
        repeat (2) @(posedge i_core_clk);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule // serial_master_model
